// ==== verilog/sram_host.sv ====
// Purpose: host controller that runs read and write cycles on a latched word memory
// Assumes: one request at a time; the memory sits on plain pins of this block
// Notes:   all pin levels come from flip-flops; data pins are split into in, out, enable
`timescale 1ns/1ps
`default_nettype none

module sram_host #(
  parameter int ADDR_WIDTH = sram_host_pkg::ADDR_WIDTH,
  parameter int DATA_WIDTH = sram_host_pkg::DATA_WIDTH
) (
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clock_en,
  // request side
  input  wire logic                  cmd_valid,
  output logic                       cmd_ready,
  input  wire logic                  cmd_write,
  input  wire logic [ADDR_WIDTH-1:0] cmd_addr,
  input  wire logic [DATA_WIDTH-1:0] cmd_wdata,
  input  wire logic [1:0]            cmd_byte_en,
  input  wire logic                  cmd_latch_addr,
  input  wire logic                  cmd_latch_data,
  output logic                       rsp_valid,
  output logic [DATA_WIDTH-1:0]      rsp_rdata,
  output logic                       rsp_write_done,
  // memory pins
  output logic [ADDR_WIDTH-1:0]      word_addr_pins,
  output logic                       chip_en,
  output logic                       chip_en_n,
  output logic                       addr_latch_enable,
  output logic                       write_strobe_n,
  output logic                       lower_byte_strobe_n,
  output logic                       upper_byte_strobe_n,
  output logic                       output_enable_n,
  output logic                       write_data_hold_enable,
  input  wire logic [DATA_WIDTH-1:0] data_pins_in,
  output logic [DATA_WIDTH-1:0]      data_pins_out,
  output logic                       data_pins_oe
);

  sram_host_pkg::state_type state_reg;
  sram_host_pkg::state_type state_next;
  logic [3:0]               count_reg;
  logic                     write_reg;
  logic [1:0]               byte_en_reg;
  logic                     latch_addr_reg;
  logic                     latch_data_reg;
  logic                     accept;
  logic                     count_done;
  logic                     cur_write;
  logic [1:0]               cur_byte_en;
  logic                     cur_latch_addr;
  logic                     cur_latch_data;

  pin_sync_if data_sync ();

  pin_sync #(
    .WIDTH (DATA_WIDTH)
  ) data_sync_inst (
    .clock    (clock),
    .rst      (rst),
    .clock_en (clock_en),
    .pin_in   (data_pins_in),
    .sync     (data_sync.producer)
  );

  // ----------------------------------------
  // request acceptance
  // ----------------------------------------
  assign cmd_ready  = (state_reg == sram_host_pkg::ST_IDLE);
  assign accept     = cmd_valid && cmd_ready && clock_en;
  assign count_done = (count_reg == 4'h0);

  // fields in force for the cycle being entered
  assign cur_write      = accept ? cmd_write      : write_reg;
  assign cur_byte_en    = accept ? cmd_byte_en    : byte_en_reg;
  assign cur_latch_addr = accept ? cmd_latch_addr : latch_addr_reg;
  assign cur_latch_data = accept ? cmd_latch_data : latch_data_reg;

  // ----------------------------------------
  // sequencer
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      sram_host_pkg::ST_IDLE: begin
        if (accept) begin
          state_next = sram_host_pkg::ST_SETUP;
        end
      end
      sram_host_pkg::ST_SETUP: state_next = sram_host_pkg::ST_LATCH;
      sram_host_pkg::ST_LATCH: state_next = sram_host_pkg::ST_STROBE;
      sram_host_pkg::ST_STROBE: begin
        if (count_done) begin
          state_next = write_reg ? sram_host_pkg::ST_RECOVER : sram_host_pkg::ST_READ_WAIT;
        end
      end
      sram_host_pkg::ST_READ_WAIT: begin
        if (data_sync.stable) begin
          state_next = sram_host_pkg::ST_RECOVER;
        end
      end
      sram_host_pkg::ST_RECOVER: state_next = sram_host_pkg::ST_IDLE;
      default: state_next = sram_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= sram_host_pkg::ST_IDLE;
    end else if (clock_en) begin
      state_reg <= state_next;
    end
  end

  // strobe length counter: write pulse or read access plus sync depth
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      count_reg <= sram_host_pkg::COUNT_RESET;
    end else if (clock_en) begin
      if (state_reg == sram_host_pkg::ST_LATCH) begin
        count_reg <= write_reg ? 4'(sram_host_pkg::WRITE_PULSE_CYCLES - 1)
                               : 4'(sram_host_pkg::READ_WAIT_CYCLES - 1);
      end else if (!count_done) begin
        count_reg <= count_reg - 4'h1;
      end
    end
  end

  // request fields held for the whole cycle so pins stay steady
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_reg      <= 1'b0;
      byte_en_reg    <= 2'h0;
      latch_addr_reg <= 1'b0;
      latch_data_reg <= 1'b0;
    end else if (accept) begin
      write_reg      <= cmd_write;
      byte_en_reg    <= cmd_byte_en;
      latch_addr_reg <= cmd_latch_addr;
      latch_data_reg <= cmd_latch_data;
    end
  end

  // ----------------------------------------
  // address, selection and latch pins
  // ----------------------------------------
  // address and enables stay on the pins from setup to recovery, which
  // covers hold around the latch fall and lets the live path work too
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      word_addr_pins    <= sram_host_pkg::ADDR_RESET;
      chip_en           <= 1'b0;
      chip_en_n         <= 1'b1;
      addr_latch_enable <= 1'b1;
    end else if (clock_en) begin
      if (accept) begin
        word_addr_pins <= cmd_addr;
      end
      chip_en   <= (state_next != sram_host_pkg::ST_IDLE);
      chip_en_n <= (state_next == sram_host_pkg::ST_IDLE);
      addr_latch_enable <= !(cur_latch_addr && (state_next != sram_host_pkg::ST_IDLE)
                             && (state_next != sram_host_pkg::ST_SETUP));
    end
  end

  // ----------------------------------------
  // strobes and output enable
  // ----------------------------------------
  // selection leads the write strobe by two cycles and outlasts it by one, so the strobe alone bounds each write
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      write_strobe_n      <= 1'b1;
      lower_byte_strobe_n <= 1'b1;
      upper_byte_strobe_n <= 1'b1;
      output_enable_n     <= 1'b1;
    end else if (clock_en) begin
      write_strobe_n <= !(cur_write && (state_next == sram_host_pkg::ST_STROBE));
      // byte strobes lead the write strobe by a cycle for setup
      if (cur_write && ((state_next == sram_host_pkg::ST_LATCH) ||
                        (state_next == sram_host_pkg::ST_STROBE))) begin
        lower_byte_strobe_n <= !cur_byte_en[0];
        upper_byte_strobe_n <= !cur_byte_en[1];
      end else begin
        lower_byte_strobe_n <= 1'b1;
        upper_byte_strobe_n <= 1'b1;
      end
      output_enable_n <= !(!cur_write && ((state_next == sram_host_pkg::ST_STROBE) ||
                           (state_next == sram_host_pkg::ST_READ_WAIT)));
    end
  end

  // ----------------------------------------
  // write data path
  // ----------------------------------------
  // latched writes drop the hold enable with the strobe; aborts never latch undriven pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      data_pins_out          <= sram_host_pkg::DATA_RESET;
      data_pins_oe           <= 1'b0;
      write_data_hold_enable <= 1'b1;
    end else if (clock_en) begin
      if (accept) begin
        data_pins_out <= cmd_wdata;
      end
      data_pins_oe <= cur_write && (cur_byte_en != 2'h0) &&
                      (state_next != sram_host_pkg::ST_IDLE);
      write_data_hold_enable <= !(cur_write && cur_latch_data && (cur_byte_en != 2'h0) &&
                                  ((state_next == sram_host_pkg::ST_STROBE) ||
                                   (state_next == sram_host_pkg::ST_RECOVER)));
    end
  end

  // ----------------------------------------
  // responses
  // ----------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      rsp_valid      <= 1'b0;
      rsp_rdata      <= sram_host_pkg::DATA_RESET;
      rsp_write_done <= 1'b0;
    end else if (clock_en) begin
      rsp_valid      <= 1'b0;
      rsp_write_done <= 1'b0;
      if ((state_reg == sram_host_pkg::ST_READ_WAIT) && data_sync.stable) begin
        rsp_valid <= 1'b1;
        rsp_rdata <= data_sync.stable_value;
      end
      if ((state_reg == sram_host_pkg::ST_RECOVER) && write_reg) begin
        rsp_write_done <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  property p_addr_hold;
    @(posedge clock) disable iff (rst)
    $fell(addr_latch_enable) |=> $stable(word_addr_pins) && $stable(chip_en);
  endproperty
  a_addr_hold: assert property (p_addr_hold)
    else $error("address moved right after latch enable fell");
  property p_drive_needs_select;
    @(posedge clock) disable iff (rst)
    data_pins_oe |-> chip_en && !chip_en_n;
  endproperty
  a_drive_needs_select: assert property (p_drive_needs_select)
    else $error("data driven while memory not selected");
  property p_no_contention;
    @(posedge clock) disable iff (rst)
    !output_enable_n |-> !data_pins_oe && write_strobe_n;
  endproperty
  a_no_contention: assert property (p_no_contention)
    else $error("output enable low while host drives or writes");
  property p_abort_undriven;
    @(posedge clock) disable iff (rst)
    !write_strobe_n && lower_byte_strobe_n && upper_byte_strobe_n |-> !data_pins_oe;
  endproperty
  a_abort_undriven: assert property (p_abort_undriven)
    else $error("aborted write drives the data pins");
  property p_strobe_setup;
    @(posedge clock) disable iff (rst)
    $fell(write_strobe_n) |-> $stable(lower_byte_strobe_n) && $stable(upper_byte_strobe_n);
  endproperty
  a_strobe_setup: assert property (p_strobe_setup)
    else $error("byte strobes changed with the write strobe fall");
  property p_write_ends_selected;
    @(posedge clock) disable iff (rst)
    $rose(write_strobe_n) |-> chip_en && !chip_en_n && data_pins_oe == $past(data_pins_oe);
  endproperty
  a_write_ends_selected: assert property (p_write_ends_selected)
    else $error("selection dropped before the write strobe rose");
  property p_word_write;
    @(posedge clock) disable iff (rst)
    !write_strobe_n && !lower_byte_strobe_n && !upper_byte_strobe_n |-> data_pins_oe;
  endproperty
  a_word_write: assert property (p_word_write)
    else $error("word write without data on the pins");
  property p_data_held;
    @(posedge clock) disable iff (rst || !clock_en)
    $fell(write_data_hold_enable) |-> data_pins_oe ##1 $stable(data_pins_out) && data_pins_oe;
  endproperty
  a_data_held: assert property (p_data_held)
    else $error("write data not held around hold enable fall");
  property p_read_bounded;
    @(posedge clock) disable iff (rst || !clock_en)
    $fell(output_enable_n) |-> ##[3:40] rsp_valid;
  endproperty
  a_read_bounded: assert property (p_read_bounded)
    else $error("read answer missing after output enable");

endmodule

`default_nettype wire

// ==== verilog/sram_host_pkg.sv ====
// Purpose: constants, states and timing for the latched word memory host controller
// Assumes: 20 MHz controller clock; memory of the slowest listed speed grade
// Notes:   Operation summary follows

package sram_host_pkg;

  localparam int ADDR_WIDTH      = 14;
  localparam int DATA_WIDTH      = 16;
  localparam int SYNC_STAGES     = 3;

  // timing, in ns as printed, converted to whole clock cycles
  localparam int CLOCK_PERIOD_NS = 50;
  localparam int WRITE_PULSE_NS  = 20;
  localparam int ACCESS_NS       = 25;
  localparam int WRITE_PULSE_CYCLES =
    ((WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS) < 1 ? 1 :
    ((WRITE_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  localparam int ACCESS_CYCLES =
    ((ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS) < 1 ? 1 :
    ((ACCESS_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS);
  // read waits for the access time plus the synchroniser depth
  localparam int READ_WAIT_CYCLES = ACCESS_CYCLES + SYNC_STAGES;

  localparam logic [3:0]  COUNT_RESET = 4'h0;
  localparam logic [15:0] DATA_RESET  = 16'h0000;
  localparam logic [13:0] ADDR_RESET  = 14'h0000;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_LATCH,
    ST_STROBE,
    ST_READ_WAIT,
    ST_RECOVER
  } state_type;

endpackage

// ==== verilog/pin_sync_if.sv ====
// Purpose: carries the data pin synchroniser result to the sequencer
// Assumes: one clock domain on both sides
// Notes:   producer is the synchroniser, consumer the sequencer
`timescale 1ns/1ps
`default_nettype none

interface pin_sync_if;
  logic [15:0] stable_value;
  logic        stable;

  modport producer (output stable_value, output stable);
  modport consumer (input stable_value, input stable);
endinterface

`default_nettype wire

// ==== verilog/pin_sync.sv ====
// Purpose: three-stage synchroniser for the memory data pins
// Assumes: pins change only while the memory drives them
// Notes:   a word counts once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst,
  input  wire logic             clock_en,
  input  wire logic [WIDTH-1:0] pin_in,
  pin_sync_if.producer          sync
);

  logic [WIDTH-1:0] stage1_reg;
  logic [WIDTH-1:0] stage2_reg;
  logic [WIDTH-1:0] stage3_reg;

  // ----------------------------------------
  // synchroniser chain
  // ----------------------------------------
  // stage1 feeds stage2 only, so no logic sees a metastable bit
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      stage2_reg <= '0;
      stage3_reg <= '0;
    end else if (clock_en) begin
      stage1_reg <= pin_in;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // a bus that still moves shows disagreement between the later stages
  assign sync.stable       = (stage2_reg == stage3_reg);
  assign sync.stable_value = stage3_reg;

endmodule

`default_nettype wire

// ==== dv/latched_mem_model.sv ====
// Purpose: behavioural latched word memory on the far side of the host
// Assumes: the bench resolves the shared data wire and feeds it back in
// Notes:   read data settles ACCESS_NS after the address reaches the core
`timescale 1ns/1ps
`default_nettype none

module latched_mem_model #(
  parameter int ACCESS_NS = 20
) (
  input  wire logic [13:0] word_addr_pins,
  input  wire logic        chip_en,
  input  wire logic        chip_en_n,
  input  wire logic        addr_latch_enable,
  input  wire logic        write_strobe_n,
  input  wire logic        lower_byte_strobe_n,
  input  wire logic        upper_byte_strobe_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_data_hold_enable,
  input  wire logic [15:0] data_pins,
  output logic [15:0]      drive_data,
  output logic             drive_en
);
  // -------------------------------------------------------------
  // core, input latches and drivers
  // -------------------------------------------------------------
  logic [15:0] core [0:16383];
  logic [13:0] addr_hold;
  logic        ce_hold;
  logic        ce_n_hold;
  logic [15:0] data_hold;
  logic        abort_hold = 1'b0;
  logic        selected;
  logic        writing;

  // address and enables flow while the latch is open, freeze on its fall
  always @* begin
    if (addr_latch_enable) begin
      addr_hold = word_addr_pins;
      ce_hold   = chip_en;
      ce_n_hold = chip_en_n;
    end
  end

  // write data flows while the hold enable is high
  always @* begin
    if (write_data_hold_enable) begin
      data_hold = data_pins;
    end
  end

  assign selected = ce_hold & ~ce_n_hold;
  assign writing  = selected & ~write_strobe_n;

  // byte strobes both high ahead of the strobe fall cancel the whole write
  always @(negedge write_strobe_n) begin
    abort_hold = lower_byte_strobe_n & upper_byte_strobe_n;
  end

  // level-sensitive store, so a write ends on whichever enable leaves first
  always @* begin
    if (writing && !abort_hold) begin
      if (!lower_byte_strobe_n) begin
        core[addr_hold][7:0] = data_hold[7:0];
      end
      if (!upper_byte_strobe_n) begin
        core[addr_hold][15:8] = data_hold[15:8];
      end
    end
  end

  // unknown enables at power-up never turn the drivers on
  assign drive_en = (selected && write_strobe_n && !output_enable_n) === 1'b1;
  assign #(ACCESS_NS) drive_data = core[addr_hold];
endmodule

`default_nettype wire

// ==== dv/tb_sram_host.sv ====
// Purpose: self-checking bench for the latched word memory host
// Assumes: one request in flight; memory model on the far side
// Notes:   pins are sampled on falling edges where they are settled
`timescale 1ns/1ps
`default_nettype none

module tb_sram_host;
  logic        clock = 1'b0;
  logic        rst = 1'b1;
  logic        clock_en = 1'b1;
  logic        cmd_valid = 1'b0;
  logic        cmd_write = 1'b0;
  logic [13:0] cmd_addr = 14'h0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic [1:0]  cmd_byte_en = 2'h0;
  logic        cmd_latch_addr = 1'b0;
  logic        cmd_latch_data = 1'b0;
  logic        cmd_ready, rsp_valid, rsp_write_done;
  logic [15:0] rsp_rdata, data_pins_in, data_pins_out, mem_data, bus_last;
  logic [13:0] word_addr_pins, prev_addr;
  logic        chip_en, chip_en_n, addr_latch_enable, write_strobe_n, prev_ale;
  logic        lower_byte_strobe_n, upper_byte_strobe_n, output_enable_n;
  logic        write_data_hold_enable, data_pins_oe, mem_en;
  logic [1:0]  cur_be = 2'h0;
  int          bad_count = 0;
  int          compares = 0;
  int          cycles = 0;

  always #25 clock = ~clock;

  sram_host DUT (.clock(clock), .rst(rst), .clock_en(clock_en), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_addr(cmd_addr),
    .cmd_wdata(cmd_wdata), .cmd_byte_en(cmd_byte_en), .cmd_latch_addr(cmd_latch_addr),
    .cmd_latch_data(cmd_latch_data), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .rsp_write_done(rsp_write_done), .word_addr_pins(word_addr_pins), .chip_en(chip_en),
    .chip_en_n(chip_en_n), .addr_latch_enable(addr_latch_enable),
    .write_strobe_n(write_strobe_n), .lower_byte_strobe_n(lower_byte_strobe_n),
    .upper_byte_strobe_n(upper_byte_strobe_n), .output_enable_n(output_enable_n),
    .write_data_hold_enable(write_data_hold_enable), .data_pins_in(data_pins_in),
    .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));

  latched_mem_model partner (.word_addr_pins(word_addr_pins), .chip_en(chip_en),
    .chip_en_n(chip_en_n), .addr_latch_enable(addr_latch_enable),
    .write_strobe_n(write_strobe_n), .lower_byte_strobe_n(lower_byte_strobe_n),
    .upper_byte_strobe_n(upper_byte_strobe_n), .output_enable_n(output_enable_n),
    .write_data_hold_enable(write_data_hold_enable), .data_pins(data_pins_in),
    .drive_data(mem_data), .drive_en(mem_en));

  // undriven wire shows the inverse of its last value, never a lucky match
  always @(posedge clock) begin
    if (data_pins_oe === 1'b1) bus_last <= data_pins_out;
    else if (mem_en) bus_last <= mem_data;
  end
  assign data_pins_in = (data_pins_oe === 1'b1) ? data_pins_out : mem_en ? mem_data : ~bus_last;

  task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t ns got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // -------------------------------------------------------------
  // pin monitor and hang guard
  // -------------------------------------------------------------
  always @(negedge clock) begin
    if (!rst && write_strobe_n === 1'b0) begin
      check_word({14'h0, chip_en, chip_en_n}, 16'h0002);
      check_word({14'h0, upper_byte_strobe_n, lower_byte_strobe_n}, {14'h0, ~cur_be});
      check_word({15'h0, data_pins_oe}, {15'h0, |cur_be});
    end
    if (!rst && output_enable_n === 1'b0) check_word({15'h0, write_strobe_n}, 16'h0001);
    if (!rst && !prev_ale && !addr_latch_enable) check_word(word_addr_pins, prev_addr);
    check_word({15'h0, data_pins_oe & mem_en}, 16'h0000);
    prev_ale  <= addr_latch_enable;
    prev_addr <= word_addr_pins;
  end

  // the whole run needs well under a thousand cycles
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      bad_count++;
      complete_run();
    end
  end

  // one request: hold it until taken, then wait for its answer
  task automatic run_req(input logic w, input logic [13:0] a, input logic [15:0] d,
                         input logic [1:0] be, input logic la, input logic ld,
                         output logic [15:0] rd, output int lat);
    logic seen;
    seen = 1'b0;
    lat  = 0;
    rd   = 16'h0000;
    @(posedge clock);
    cmd_valid      <= 1'b1;
    cmd_write      <= w;
    cmd_addr       <= a;
    cmd_wdata      <= d;
    cmd_byte_en    <= be;
    cmd_latch_addr <= la;
    cmd_latch_data <= ld;
    cur_be         <= w ? be : 2'h0;
    while (!seen) begin
      @(negedge clock);
      seen = (cmd_ready === 1'b1);
      @(posedge clock);
    end
    cmd_valid <= 1'b0;
    for (int n = 1; n < 40 && lat == 0; n++) begin
      @(negedge clock);
      if ((w ? rsp_write_done : rsp_valid) === 1'b1) begin
        lat = n - 1;
        rd  = rsp_rdata;
      end
    end
  endtask

  task automatic write_word(input logic [13:0] a, input logic [15:0] d, input logic [1:0] be,
                            input logic la, input logic ld);
    logic [15:0] rd;
    int          lat;
    run_req(1'b1, a, d, be, la, ld, rd, lat);
    // setup, latch and recovery cycles around the write pulse
    check_word(lat[15:0], 16'(3 + sram_host_pkg::WRITE_PULSE_CYCLES));
  endtask

  task automatic read_expect(input logic [13:0] a, input logic la, input logic [15:0] exp);
    logic [15:0] rd;
    int          lat;
    run_req(1'b0, a, 16'h0000, 2'h0, la, 1'b0, rd, lat);
    // setup, latch and one capture cycle around the access and sync wait
    check_word(lat[15:0], 16'(3 + sram_host_pkg::READ_WAIT_CYCLES));
    check_word(rd, exp);
  endtask

  // idle pins right after reset: deselected, memory not driving
  task automatic sc_reset_levels;
    check_word({10'h0, chip_en, chip_en_n, addr_latch_enable, write_strobe_n, data_pins_oe,
                mem_en}, 16'h001c);
  endtask

  // full words at both ends of the array in all four latch modes
  task automatic sc_word_modes;
    logic [13:0] at [4];
    at = '{14'h0000, 14'h3fff, 14'h1555, 14'h2aaa};
    for (int i = 0; i < 4; i++) write_word(at[i], 16'ha5c3 ^ 16'(i * 16'h1111), 2'h3,
                                           i[0], i[1]);
    for (int i = 0; i < 4; i++) read_expect(at[i], ~i[0], 16'ha5c3 ^ 16'(i * 16'h1111));
  endtask

  // each byte strobe alone leaves the other byte untouched
  task automatic sc_bytes;
    write_word(14'h0100, 16'h1234, 2'h3, 1'b0, 1'b0);
    write_word(14'h0100, 16'habcd, 2'h1, 1'b0, 1'b1);
    read_expect(14'h0100, 1'b1, 16'h12cd);
    write_word(14'h0100, 16'h5678, 2'h2, 1'b1, 1'b0);
    read_expect(14'h0100, 1'b0, 16'h56cd);
  endtask

  // no byte strobes: write cancelled, contents kept, pins stay undriven
  task automatic sc_abort;
    write_word(14'h0100, 16'hdead, 2'h0, 1'b1, 1'b1);
    read_expect(14'h0100, 1'b1, 16'h56cd);
  endtask

  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'b0;
    @(negedge clock);
    sc_reset_levels();
    sc_word_modes();
    sc_bytes();
    sc_abort();
    repeat (3) @(posedge clock);
    complete_run();
  end
endmodule

`default_nettype wire
